// ---- hdl/apm_pm1_regs.sv ----
// Purpose: PM1 runtime register bank shared by host (I/O) and controller.
// Assumes: Host I/O decode is done against a programmed base; host and
//          controller strobes are one-cycle pulses on this clock.
// Notes:   Controller writes win over host writes in the same cycle.
`default_nettype none
// Function
// - Decode registers as byte offsets from host base and fixed controller base.
// - Offsets 00h, 02h, 06h, 07h are reserved, read-only.
// - Offset 04h is reserved, read-only, reads zero.
// - Status bit 7 wake status: controller sets/clears, host one clears.
// - Status bit 3 override status, set by controller to simulate.
// - Status bit 2 alarm status, set by controller to simulate.
// - Status bit 1 sleep-button status, set by controller.
// - Status bit 0 power-button status, set by controller.
// - Controller status writes load the written value directly.
// - Host status write of one clears; zero leaves unchanged.
// - Status bits clear on main-well reset; default zero.
// - Enable bits 2:0 host read/write, controller read-only.
// - Controller writes to enables and host control fields are ignored.
// - Sleep type bits 4:2 host read/write, controller reads; reset zero.
// - Override enable bit 1 host-writable; bits 7:6 and 0 reserved.
// - Sleep enable: host one sets, host reads zero, controller one clears.
// - Interrupt controller on host write of status and of enable register.
// - Drive active-low host SCI pin while SCI request bit is one.
module apm_pm1_regs #(
    parameter logic [15:0] HOST_BASE_DEFAULT = 16'h0000
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [15:0] host_base,
    input  wire logic [15:0] host_addr,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [7:0]  host_wdata,
    output var  logic [7:0]  host_rdata,
    output var  logic        host_hit,
    input  wire logic [31:0] ec_addr,
    input  wire logic        ec_wr,
    input  wire logic        ec_rd,
    input  wire logic [7:0]  ec_wdata,
    output var  logic [7:0]  ec_rdata,
    output var  logic        ec_hit,
    output var  logic        host_status_write_irq,
    output var  logic        host_enable_write_irq,
    output var  logic        host_sci_pin_n,
    output var  logic [2:0]  sleep_type,
    output var  logic        sleep_enable,
    output var  logic        power_button_override_enable
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] enable;
        logic [7:0] control;
        logic [7:0] ec_pm;
        logic [7:0] host_rdata;
        logic       host_hit;
        logic [7:0] ec_rdata;
        logic       ec_hit;
        logic       sts_irq;
        logic       en_irq;
        logic       sci_n;
    } apm_state_t;

    apm_state_t state_reg;
    apm_state_t state_next;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic [15:0] host_off;
    logic        host_in;
    logic [31:0] ec_off;
    logic [31:0] ec_only_off;
    logic        ec_in;
    logic        ec_in_only;
    logic [7:0]  host_idx;
    logic [7:0]  ec_idx;

    always_comb begin
        host_off    = host_addr - host_base;
        host_in     = (host_addr >= host_base) && (host_off < 16'h0008);
        host_idx    = host_off[7:0];
        ec_off      = ec_addr - apm_pkg::EC_BASE;
        ec_only_off = ec_addr - apm_pkg::EC_ONLY_BASE;
        ec_in       = (ec_addr >= apm_pkg::EC_BASE) && (ec_off < 32'h0000_0008);
        ec_in_only  = (ec_only_off == 32'h0000_0000) || (ec_only_off < 32'h0000_0008)
                      || (ec_only_off == {24'h00_0000, apm_pkg::OFF_EC_PM_STS});
        ec_in_only  = ec_in_only && (ec_addr >= apm_pkg::EC_ONLY_BASE);
        ec_idx      = ec_in ? ec_off[7:0] : ec_only_off[7:0];
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] sts;
        logic [7:0] ctl;
        state_next = state_reg;
        sts = state_reg.status;
        ctl = state_reg.control;
        state_next.sts_irq  = 1'b0;
        state_next.en_irq   = 1'b0;
        state_next.host_hit = host_in && (host_wr || host_rd);
        state_next.ec_hit   = (ec_in || ec_in_only) && (ec_wr || ec_rd);

        // Host side writes.
        if (host_in && host_wr) begin
            unique case (host_idx)
                apm_pkg::OFF_STATUS_HIGH: begin
                    sts = sts & ~(host_wdata & apm_pkg::STATUS_MASK);
                    state_next.sts_irq = 1'b1;
                end
                apm_pkg::OFF_ENABLE_HIGH: begin
                    state_next.enable = host_wdata & apm_pkg::ENABLE_MASK;
                    state_next.en_irq = 1'b1;
                end
                apm_pkg::OFF_CONTROL_HIGH: begin
                    ctl[4:2] = host_wdata[4:2];
                    ctl[1]   = host_wdata[1];
                    if (host_wdata[5]) begin
                        ctl[5] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Controller writes; later in the process so they take precedence.
        if ((ec_in || ec_in_only) && ec_wr) begin
            unique case (ec_idx)
                apm_pkg::OFF_STATUS_HIGH: begin
                    if (ec_in || ec_idx != apm_pkg::OFF_EC_PM_STS) begin
                        // Wake, override, alarm, sleep and power status.
                        // All load straight from the write data.
                        sts = ec_wdata & apm_pkg::STATUS_MASK;
                    end
                end
                apm_pkg::OFF_CONTROL_HIGH: begin
                    if (ec_wdata[5]) begin
                        ctl[5] = 1'b0;
                    end
                end
                apm_pkg::OFF_EC_PM_STS: begin
                    if (ec_in_only) begin
                        state_next.ec_pm = ec_wdata;
                    end
                end
                default: begin
                    // Enable and host-owned fields are read-only here.
                end
            endcase
        end
        state_next.status  = sts;
        state_next.control = ctl & 8'h3E;

        // Read data; reserved registers read zero.
        state_next.host_rdata = 8'h00;
        if (host_in && host_rd) begin
            unique case (host_idx)
                apm_pkg::OFF_STATUS_HIGH:  state_next.host_rdata = state_reg.status;
                apm_pkg::OFF_ENABLE_HIGH:  state_next.host_rdata = state_reg.enable;
                apm_pkg::OFF_CONTROL_HIGH: begin
                    state_next.host_rdata = state_reg.control & 8'h1E;
                end
                default:                   state_next.host_rdata = 8'h00;
            endcase
        end
        state_next.ec_rdata = 8'h00;
        if ((ec_in || ec_in_only) && ec_rd) begin
            unique case (ec_idx)
                apm_pkg::OFF_STATUS_HIGH:  state_next.ec_rdata = state_reg.status;
                apm_pkg::OFF_ENABLE_HIGH:  state_next.ec_rdata = state_reg.enable;
                apm_pkg::OFF_CONTROL_HIGH: state_next.ec_rdata = state_reg.control;
                apm_pkg::OFF_EC_PM_STS:    state_next.ec_rdata = state_reg.ec_pm;
                default:                   state_next.ec_rdata = 8'h00;
            endcase
        end

        state_next.sci_n = ~state_next.ec_pm[0];
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg         <= '0;
            state_reg.sci_n   <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from state flip-flops
    // ----------------------------------------------------------------
    always_comb begin
        host_rdata                   = state_reg.host_rdata;
        host_hit                     = state_reg.host_hit;
        ec_rdata                     = state_reg.ec_rdata;
        ec_hit                       = state_reg.ec_hit;
        host_status_write_irq        = state_reg.sts_irq;
        host_enable_write_irq        = state_reg.en_irq;
        host_sci_pin_n               = state_reg.sci_n;
        sleep_type                   = state_reg.control[4:2];
        sleep_enable                 = state_reg.control[5];
        power_button_override_enable = state_reg.control[1];
    end

endmodule // apm_pm1_regs
`default_nettype wire

// ---- include/apm_pkg.sv ----
// Purpose: Constants shared by the PM1 runtime register bank.
// Assumes: Byte-wide register ports on host and controller sides.
// Notes:   Offsets are byte offsets from each side's base.
`default_nettype none
package apm_pkg;
    localparam logic [7:0]  OFF_STATUS_LOW   = 8'h00;
    localparam logic [7:0]  OFF_STATUS_HIGH  = 8'h01;
    localparam logic [7:0]  OFF_ENABLE_LOW   = 8'h02;
    localparam logic [7:0]  OFF_ENABLE_HIGH  = 8'h03;
    localparam logic [7:0]  OFF_CONTROL_LOW  = 8'h04;
    localparam logic [7:0]  OFF_CONTROL_HIGH = 8'h05;
    localparam logic [7:0]  OFF_PM2_LOW      = 8'h06;
    localparam logic [7:0]  OFF_PM2_HIGH     = 8'h07;
    localparam logic [7:0]  OFF_EC_PM_STS    = 8'h10;
    localparam logic [31:0] EC_BASE          = 32'h400F_1400;
    localparam logic [31:0] EC_ONLY_BASE     = 32'h400F_1500;
    localparam logic [7:0]  STATUS_MASK      = 8'h8F;
    localparam logic [7:0]  ENABLE_MASK      = 8'h07;
    localparam logic [7:0]  RESET_VALUE      = 8'h00;
    localparam int          SLEEP_TYPE_LSB   = 2;
    localparam int          SLEEP_ENABLE_BIT = 5;
    localparam int          OVR_ENABLE_BIT   = 1;
endpackage : apm_pkg
`default_nettype wire

// ---- testbench/apm_host_model.sv ----
// Purpose: Host I/O cycle model for the PM1 bank.
// Assumes: One-cycle strobes, answer one cycle later.
// Notes:   Released lines show the inverse so stale values cannot pass.
`default_nettype none
module apm_host_model #(
    parameter logic [15:0] BASE = 16'h0000
) (
    input  wire logic        clock,
    input  wire logic [7:0]  host_rdata,
    output var  logic [15:0] host_addr,
    output var  logic        host_wr,
    output var  logic        host_rd,
    output var  logic [7:0]  host_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        host_addr = 16'h0000;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
    end
    task automatic xfer(input logic wr, input logic [7:0] off, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clock);
        #1;
        host_addr = BASE + {8'h00, off};
        host_wdata = d;
        host_wr = wr;
        host_rd = !wr;
        @(posedge clock);
        #1;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = ~host_addr;
        host_wdata = ~host_wdata;
        q = host_rdata;
    endtask
endmodule // apm_host_model
`default_nettype wire

// ---- testbench/apm_pm1_checker.sv ----
// Purpose: Port assertions for the PM1 register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every bank instance.
`default_nettype none
module apm_pm1_checker (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [15:0] host_base,
    input wire logic [15:0] host_addr,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic [7:0]  host_wdata,
    input wire logic [7:0]  host_rdata,
    input wire logic        host_hit,
    input wire logic [31:0] ec_addr,
    input wire logic        ec_wr,
    input wire logic        ec_rd,
    input wire logic [7:0]  ec_wdata,
    input wire logic        ec_hit,
    input wire logic        host_status_write_irq,
    input wire logic        host_enable_write_irq,
    input wire logic        host_sci_pin_n,
    input wire logic [2:0]  sleep_type,
    input wire logic        power_button_override_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    status_irq_a:
        assert property (host_wr && host_addr == host_base + 16'h1 |=> host_status_write_irq)
        else $error("status write irq missing");
    enable_irq_a:
        assert property (host_wr && host_addr == host_base + 16'h3 |=> host_enable_write_irq)
        else $error("enable write irq missing");
    irq_cause_a:
        assert property (host_status_write_irq |-> $past(host_wr)
            && $past(host_addr) == $past(host_base) + 16'h1) else $error("stray status irq");
    host_hit_a:
        assert property (host_rd && 16'(host_addr - host_base) < 16'h8 |=> host_hit)
        else $error("host hit missing");
    sci_low_a:
        assert property (ec_wr && ec_addr == 32'h400F_1510 && ec_wdata[0] |=> !host_sci_pin_n)
        else $error("sci pin not low");
    sleep_type_a:
        assert property (host_wr && host_addr == host_base + 16'h5
            |=> sleep_type == 3'($past(host_wdata) >> 2)) else $error("sleep type not loaded");
    ec_ignore_a:
        assert property (!(host_wr && host_addr == host_base + 16'h5) |=> $stable(sleep_type)
            && $stable(power_button_override_enable)) else $error("control changed");
    rsvd_zero_a:
        assert property (host_rd && host_addr == host_base + 16'h4 |=> host_rdata == 8'h00)
        else $error("reserved reads nonzero");
    ec_hit_a:
        assert property (ec_rd && ec_addr == 32'h400F_1401 |=> ec_hit)
        else $error("controller hit missing");
    cover property (host_status_write_irq);
    cover property (host_enable_write_irq);
    cover property ($fell(host_sci_pin_n));
endmodule // apm_pm1_checker
bind apm_pm1_regs apm_pm1_checker u_chk (.clock, .rst, .host_base, .host_addr, .host_wr,
    .host_rd, .host_wdata, .host_rdata, .host_hit, .ec_addr, .ec_wr, .ec_rd, .ec_wdata, .ec_hit,
    .host_status_write_irq, .host_enable_write_irq, .host_sci_pin_n, .sleep_type,
    .power_button_override_enable);
`default_nettype wire

// ---- testbench/apm_pm1_regs_tb_top.sv ----
// Purpose: Self-checking bench for the PM1 register bank.
// Assumes: Controller side driven here, host side by the host model.
// Notes:   Every access has the one-cycle answer of the contract.
`default_nettype none
module apm_pm1_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] BASE = 16'h0620;
    localparam logic [31:0] ECB  = apm_pkg::EC_BASE;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] host_addr;
    logic        host_wr;
    logic        host_rd;
    logic [7:0]  host_wdata;
    logic [7:0]  host_rdata;
    logic [31:0] ec_addr = 32'h0;
    logic        ec_wr = 1'b0;
    logic        ec_rd = 1'b0;
    logic [7:0]  ec_wdata = 8'h00;
    logic [7:0]  ec_rdata;
    logic        host_sci_pin_n;
    logic [2:0]  sleep_type;
    logic        sleep_enable;
    logic        pbo_en;
    logic [7:0]  q;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    always #25 clock = ~clock;
    apm_host_model #(.BASE(BASE)) u_host (.clock, .host_rdata, .host_addr, .host_wr,
        .host_rd, .host_wdata);
    apm_pm1_regs u_dut (.clock, .rst, .host_base(BASE), .host_addr, .host_wr, .host_rd,
        .host_wdata, .host_rdata, .host_hit(), .ec_addr, .ec_wr, .ec_rd, .ec_wdata, .ec_rdata,
        .ec_hit(), .host_status_write_irq(), .host_enable_write_irq(), .host_sci_pin_n,
        .sleep_type, .sleep_enable, .power_button_override_enable(pbo_en));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ec_io(input logic wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        ec_addr = a;
        ec_wdata = d;
        ec_wr = wr;
        ec_rd = !wr;
        @(posedge clock);
        #1;
        ec_wr = 1'b0;
        ec_rd = 1'b0;
        ec_addr = ~ec_addr;
        ec_wdata = ~ec_wdata;
        q = ec_rdata;
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1 rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            u_host.xfer(1'b0, 8'(i), 8'h00, q);
            chk(q, 8'h00);
        end
        $display("test reset values done");
        ec_io(1'b1, ECB + 32'h1, 8'hFF);
        u_host.xfer(1'b0, 8'h01, 8'h00, q);
        chk(q, 8'h8F);
        u_host.xfer(1'b1, 8'h01, 8'h05, q);
        ec_io(1'b0, ECB + 32'h1, 8'h00);
        chk(q, 8'h8A);
        ec_io(1'b1, apm_pkg::EC_ONLY_BASE + 32'h1, 8'h00);
        ec_io(1'b0, ECB + 32'h1, 8'h00);
        chk(q, 8'h00);
        $display("test status done");
        u_host.xfer(1'b1, 8'h03, 8'hFF, q);
        ec_io(1'b1, ECB + 32'h3, 8'h00);
        ec_io(1'b0, ECB + 32'h3, 8'h00);
        chk(q, 8'h07);
        u_host.xfer(1'b1, 8'h05, 8'hFF, q);
        u_host.xfer(1'b0, 8'h05, 8'h00, q);
        chk(q, 8'h1E);
        ec_io(1'b1, ECB + 32'h5, 8'h00);
        ec_io(1'b0, ECB + 32'h5, 8'h00);
        chk(q, 8'h3E);
        ec_io(1'b1, ECB + 32'h5, 8'h20);
        chk({2'b00, sleep_enable, sleep_type, pbo_en, 1'b0}, 8'h1E);
        $display("test enable and control done");
        ec_io(1'b1, ECB + 32'h110, 8'h01);
        chk({7'h00, host_sci_pin_n}, 8'h00);
        ec_io(1'b0, ECB + 32'h110, 8'h00);
        chk(q, 8'h01);
        ec_io(1'b1, ECB + 32'h110, 8'h00);
        chk({7'h00, host_sci_pin_n}, 8'h01);
        ec_io(1'b1, ECB + 32'h1, 8'h8F);
        rst = 1'b1;
        @(posedge clock);
        #1 rst = 1'b0;
        u_host.xfer(1'b0, 8'h01, 8'h00, q);
        chk(q, 8'h00);
        $display("test sci and reset done");
        give_verdict();
    end
endmodule // apm_pm1_regs_tb_top
`default_nettype wire
